// ---- shared/hfa_pkg.sv ----
// Shared constants, types and timing counts of the converter host controller.
package hfa_pkg;

    localparam int CLK_NS = 8;

    // Timing figures in nanoseconds.
    localparam int ACQ_NS = 185;
    localparam int WAKE_NS = 360;
    localparam int WR_PULSE_NS = 250;
    localparam int RD_DELAY_NS = 250;
    localparam int READ_NS = 235;
    localparam int DONE_WAIT_NS = 1000;

    // Least times round up, the longest wait rounds down.
    localparam int ACQ_CYC = (ACQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_DELAY_CYC = (RD_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int DONE_WAIT_CYC = DONE_WAIT_NS / CLK_NS;
    localparam int CNT_W = 8;

    // Software register offsets.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RESULT = 4'h8;

    // Control register fields.
    localparam int CTRL_START = 0;
    localparam int CTRL_CHAN_LSB = 1;
    localparam int CTRL_MODE = 4;
    localparam int CTRL_EARLY = 5;
    localparam int CTRL_AWAKE = 6;
    localparam logic [1:0] OPT_INTERNAL = 2'h0;
    localparam logic [1:0] OPT_EARLY = 2'h1;
    localparam logic [1:0] OPT_PIPE = 2'h2;

    // Status register fields.
    localparam int STAT_BUSY = 0;
    localparam int STAT_VALID = 1;
    localparam int STAT_TIMEOUT = 2;
    localparam int STAT_PRIMED = 3;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic mode;
        logic shutdown_n;
        logic [2:0] chan_addr;
    } hfa_pins_t;

endpackage : hfa_pkg

// ---- src/hfa_sync.sv ----
// Three-stage synchroniser; a change counts once the last two stages agree.
module hfa_sync #(
    parameter logic INIT = 1'b1
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Data.
    input wire logic din,
    output logic dout
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            dout <= INIT;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end

endmodule : hfa_sync

// ---- src/hfa_host.sv ----
// Host controller that drives the half-flash converter through its pins.
module hfa_host (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Software register port.
    input wire logic [3:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata,
    // Converter control pins.
    output hfa_pkg::hfa_pins_t pins,
    output logic wr_rdy_o,
    output logic wr_rdy_oe,
    input wire logic wr_rdy_i,
    // Converter status and data pins.
    input wire logic done_n,
    input wire logic [7:0] result_bus
);
    typedef enum {
        ST_IDLE, ST_WAKE, ST_SETUP, ST_RD_LOW, ST_WR_LOW, ST_GAP, ST_WAIT_DONE,
        ST_READ, ST_RELEASE, ST_ACQ
    } hfa_state_t;

    hfa_state_t state;
    hfa_state_t next_state;
    logic [hfa_pkg::CNT_W-1:0] cnt;
    logic [hfa_pkg::CNT_W-1:0] next_cnt;
    logic [7:0] ctrl;
    logic [7:0] result;
    logic valid;
    logic timeout;
    logic primed;
    logic done_s;
    logic rdy_s;

    // Pin inputs from outside the clock domain.
    hfa_sync #(.INIT(1'b1)) u_sync_done (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(done_n),
        .dout(done_s)
    );
    hfa_sync #(.INIT(1'b1)) u_sync_rdy (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(wr_rdy_i),
        .dout(rdy_s)
    );

    wire logic wr_ctrl = sw_wr && (sw_addr == hfa_pkg::REG_CTRL);
    wire logic start_req = wr_ctrl && sw_wdata[hfa_pkg::CTRL_START] && (state == ST_IDLE);
    wire logic mode_wr = ctrl[hfa_pkg::CTRL_MODE];
    wire logic [1:0] opt = ctrl[hfa_pkg::CTRL_EARLY +: 2];
    wire logic awake = ctrl[hfa_pkg::CTRL_AWAKE];
    wire logic [2:0] chan = ctrl[hfa_pkg::CTRL_CHAN_LSB +: 3];
    wire logic cnt_zero = (cnt == '0);
    wire logic done_low = !done_s;
    // In read mode the ready line is a status wait; conversion done also ends it.
    wire logic rd_ready = done_low || (rdy_s && cnt_zero);
    wire logic [7:0] status = {4'h0, primed, timeout, valid, (state != ST_IDLE)};
    wire logic [7:0] next_rdata = (sw_addr == hfa_pkg::REG_CTRL) ? ctrl :
        (sw_addr == hfa_pkg::REG_STATUS) ? status :
        (sw_addr == hfa_pkg::REG_RESULT) ? result : 8'h00;

    function automatic logic [hfa_pkg::CNT_W-1:0] cyc(input int n);
        cyc = hfa_pkg::CNT_W'(n);
    endfunction : cyc

    always_comb begin
        next_state = state;
        next_cnt = cnt_zero ? cnt : cnt - 1'b1;
        unique case (state)
            ST_IDLE: begin
                if (start_req) begin
                    // Address settles an acquisition window before the strobe.
                    next_state = awake ? ST_SETUP : ST_WAKE;
                    next_cnt = awake ? cyc(hfa_pkg::ACQ_CYC) : cyc(hfa_pkg::WAKE_CYC);
                end
            end
            ST_WAKE: begin
                if (cnt_zero) begin
                    next_state = ST_SETUP;
                    next_cnt = cyc(hfa_pkg::ACQ_CYC);
                end
            end
            ST_SETUP: begin
                if (cnt_zero) begin
                    next_state = mode_wr ? ST_WR_LOW : ST_RD_LOW;
                    next_cnt = mode_wr ? cyc(hfa_pkg::WR_PULSE_CYC) : cyc(hfa_pkg::WAKE_CYC);
                end
            end
            ST_RD_LOW: begin
                // Read mode: the count masks ready until the converter has pulled it low.
                if (rd_ready) begin
                    next_state = ST_READ;
                    next_cnt = cyc(hfa_pkg::READ_CYC);
                end
            end
            ST_WR_LOW: begin
                if (cnt_zero) begin
                    if (opt == hfa_pkg::OPT_PIPE) begin
                        next_state = ST_RELEASE;
                    end else begin
                        next_state = (opt == hfa_pkg::OPT_EARLY) ? ST_GAP : ST_WAIT_DONE;
                        next_cnt = (opt == hfa_pkg::OPT_EARLY) ? cyc(hfa_pkg::RD_DELAY_CYC)
                            : cyc(hfa_pkg::DONE_WAIT_CYC);
                    end
                end
            end
            ST_GAP: begin
                if (cnt_zero) begin
                    next_state = ST_READ;
                    next_cnt = cyc(hfa_pkg::READ_CYC);
                end
            end
            ST_WAIT_DONE: begin
                if (done_low || cnt_zero) begin
                    next_state = ST_READ;
                    next_cnt = cyc(hfa_pkg::READ_CYC);
                end
            end
            ST_READ: begin
                if (cnt_zero) begin
                    next_state = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                next_state = ST_ACQ;
                next_cnt = cyc(hfa_pkg::ACQ_CYC);
            end
            ST_ACQ: begin
                if (cnt_zero) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // Strobes per state; pipelined mode drives both strobes as one.
    wire logic next_rd_low = (state == ST_RD_LOW) || (state == ST_READ)
        || ((state == ST_WR_LOW) && (opt == hfa_pkg::OPT_PIPE));
    wire logic next_wr_low = (state == ST_WR_LOW);
    // Select leads the strobes by a cycle and trails them by one, so no strobe edge is
    // ever seen with select high; it also stays low while a write-read result is awaited.
    wire logic next_cs_hold = ((state == ST_SETUP) && cnt_zero) || (state == ST_GAP)
        || (state == ST_WAIT_DONE) || (state == ST_RELEASE);
    wire logic next_cs_low = next_rd_low || next_wr_low || next_cs_hold;
    wire logic sample_now = (state == ST_READ) && cnt_zero;
    wire logic pipe_sample = (state == ST_WR_LOW) && (opt == hfa_pkg::OPT_PIPE) && cnt_zero;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pins <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, mode: 1'b0,
                shutdown_n: 1'b0, chan_addr: 3'h0};
            sw_rdata <= 8'h00;
        end else begin
            pins.cs_n <= !next_cs_low;
            pins.rd_n <= !next_rd_low;
            pins.wr_n <= !next_wr_low;
            pins.mode <= mode_wr;
            pins.shutdown_n <= awake || (state != ST_IDLE) || start_req;
            pins.chan_addr <= chan;
            sw_rdata <= sw_rd ? next_rdata : 8'h00;
        end
    end

    // The host never drives the ready line in read mode; in write-read it is our strobe.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_rdy_o <= 1'b1;
            wr_rdy_oe <= 1'b0;
        end else begin
            wr_rdy_o <= !next_wr_low;
            wr_rdy_oe <= mode_wr;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= 8'h00;
            result <= 8'h00;
            valid <= 1'b0;
            timeout <= 1'b0;
            primed <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= {sw_wdata[7:1], 1'b0};
            end
            // First result after reset only primes the converter.
            if (sample_now || pipe_sample) begin
                result <= result_bus;
                primed <= 1'b1;
                valid <= primed;
            end else if (sw_rd && (sw_addr == hfa_pkg::REG_RESULT)) begin
                valid <= 1'b0;
            end
            if ((state == ST_WAIT_DONE) && cnt_zero && !done_low) begin
                timeout <= 1'b1;
            end else if (start_req) begin
                timeout <= 1'b0;
            end
        end
    end

endmodule : hfa_host

// ---- dv/hfa_host_chk.sv ----
// Concurrent checks on the host controller's pins.
module hfa_host_chk (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Converter pins.
    input wire hfa_pkg::hfa_pins_t pins,
    input wire logic wr_rdy_o,
    input wire logic wr_rdy_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Cycles that the converter has been awake; saturates so a long idle cannot wrap it.
    localparam logic [7:0] WAKE_MIN = 8'(hfa_pkg::WAKE_CYC);
    logic [7:0] wake_cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt <= 8'h00;
        end else if (!pins.shutdown_n) begin
            wake_cnt <= 8'h00;
        end else if (wake_cnt != 8'hff) begin
            wake_cnt <= wake_cnt + 8'h01;
        end
    end
    AST_RD_NEEDS_CS: assert property (!pins.rd_n |-> !pins.cs_n)
        else $error("read strobe low without select");
    AST_WR_NEEDS_CS: assert property (wr_rdy_oe && !wr_rdy_o |-> !pins.cs_n)
        else $error("write strobe low without select");
    AST_ADDR_SETTLED: assert property ($changed(pins.chan_addr) |-> pins.cs_n [*8])
        else $error("channel changed too close to a start");
    AST_RDY_UNDRIVEN: assert property (wr_rdy_oe |-> pins.mode)
        else $error("ready pin driven in read mode");
    AST_RD_HELD: assert property ($fell(pins.rd_n) && !pins.mode |-> !pins.rd_n [*8])
        else $error("read strobe released too early");
    AST_WR_PULSE: assert property ($fell(wr_rdy_o) && wr_rdy_oe |-> !wr_rdy_o [*8])
        else $error("write pulse too short");
    AST_ACQ_GAP: assert property ($rose(pins.rd_n) && pins.mode |-> wr_rdy_o [*8])
        else $error("next write before acquisition");
    AST_WAKE_SETTLE: assert property ($rose(pins.shutdown_n) |-> pins.cs_n [*8])
        else $error("start too soon after wake");
    AST_WAKE_FULL: assert property ($fell(pins.cs_n) |-> wake_cnt >= WAKE_MIN)
        else $error("select fell before the wake time");
endmodule : hfa_host_chk
bind hfa_host hfa_host_chk i_chk (.mclk(mclk), .rst_n(rst_n), .pins(pins),
    .wr_rdy_o(wr_rdy_o), .wr_rdy_oe(wr_rdy_oe));

// ---- dv/hfa_adc_model.sv ----
// Behavioural model of the converter's digital side.
module hfa_adc_model #(
    parameter int CONV_NS = 600,
    parameter int INTL_NS = 450
) (
    // Pins from the host.
    input wire hfa_pkg::hfa_pins_t pins,
    input wire logic wr_line,
    // Pins to the host.
    output logic done_n,
    output logic rdy_pd,
    output logic [7:0] result_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] out_q = 8'h00;
    logic [7:0] nxt;
    logic [2:0] ch;
    logic first = 1'b1;
    wire live = !pins.cs_n && pins.shutdown_n;
    // A released bus shows the inverse, so a stale byte never passes.
    assign result_bus = (live && !pins.rd_n) ? out_q : ~out_q;
    function automatic logic [7:0] code(input logic [2:0] c);
        return (c == 3'h7) ? 8'hff : {c, ~c, 2'h1};
    endfunction : code
    initial {done_n, rdy_pd} = 2'b10;
    always @(negedge pins.rd_n) begin
        if (live && !pins.mode) begin
            ch = pins.chan_addr;
            rdy_pd = 1'b1;
            #(CONV_NS);
            out_q = first ? 8'h5a : code(ch);
            first = 1'b0;
            rdy_pd = 1'b0;
            done_n = 1'b0;
        end
    end
    always @(negedge wr_line) if (live && pins.mode) ch = pins.chan_addr;
    always @(posedge wr_line) begin
        if (live && pins.mode) begin
            nxt = first ? 8'h5a : code(ch);
            out_q[7:4] = nxt[7:4];
            for (int i = 0; i < INTL_NS && pins.rd_n; i++) #1;
            out_q[3:0] = nxt[3:0];
            first = 1'b0;
            done_n = 1'b0;
        end
    end
    always @(posedge pins.cs_n or posedge pins.rd_n) done_n = 1'b1;
endmodule : hfa_adc_model

// ---- dv/hfa_host_bench.sv ----
// Self-checking bench of the converter host controller.
module hfa_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [7:0] sw_rdata;
    logic [7:0] result_bus;
    logic wr_rdy_o;
    logic wr_rdy_oe;
    logic done_n;
    logic rdy_pd;
    hfa_pkg::hfa_pins_t pins;
    int err_count = 0;
    int n_checks = 0;
    // The ready line has a board pull-up; the converter only pulls it down.
    wire wr_line = wr_rdy_oe ? wr_rdy_o : !rdy_pd;
    hfa_host i_dut (.mclk(mclk), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pins(pins), .wr_rdy_o(wr_rdy_o),
        .wr_rdy_oe(wr_rdy_oe), .wr_rdy_i(wr_line), .done_n(done_n), .result_bus(result_bus));
    hfa_adc_model i_adc (.pins(pins), .wr_line(wr_line), .done_n(done_n), .rdy_pd(rdy_pd),
        .result_bus(result_bus));
    initial begin
        forever #4 mclk = ~mclk;
    end
    function automatic logic [7:0] code(input logic [2:0] c);
        return (c == 3'h7) ? 8'hff : {c, ~c, 2'h1};
    endfunction : code
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge mclk);
        sw_wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge mclk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask : rd_reg
    // Starts one conversion, polls busy under a bound, checks status, then the byte when valid is expected.
    task automatic conv(input logic [2:0] ch, input logic md, input logic [1:0] opt,
        input logic [7:0] exp, input logic vld);
        logic [7:0] s;
        wr_reg(hfa_pkg::REG_CTRL, {1'b0, opt, md, ch, 1'b1});
        s = 8'h01;
        for (int i = 0; i < 400 && s[0] !== 1'b0; i++) rd_reg(hfa_pkg::REG_STATUS, s);
        chk8("status", {5'h00, 1'b0, vld, 1'b0}, {5'h00, s[2:0]});
        if (vld) begin
            rd_reg(hfa_pkg::REG_RESULT, s);
            chk8("result", exp, s);
        end
    endtask : conv
    task automatic t_first();
        logic [7:0] s;
        conv(3'h0, 1'b0, hfa_pkg::OPT_INTERNAL, 8'h00, 1'b0);
        rd_reg(hfa_pkg::REG_STATUS, s);
        chk8("primed", 8'h01, {7'h0, s[hfa_pkg::STAT_PRIMED]});
    endtask : t_first
    task automatic t_read_mode();
        for (int c = 0; c < 8; c++) begin
            conv(3'(c), 1'b0, hfa_pkg::OPT_INTERNAL, code(3'(c)), 1'b1);
        end
    endtask : t_read_mode
    task automatic t_write_read();
        conv(3'h3, 1'b1, hfa_pkg::OPT_INTERNAL, code(3'h3), 1'b1);
        conv(3'h5, 1'b1, hfa_pkg::OPT_EARLY, code(3'h5), 1'b1);
    endtask : t_write_read
    // Each tied pulse returns the conversion before it.
    task automatic t_pipelined();
        conv(3'h2, 1'b1, hfa_pkg::OPT_PIPE, code(3'h5), 1'b1);
        conv(3'h6, 1'b1, hfa_pkg::OPT_PIPE, code(3'h2), 1'b1);
    endtask : t_pipelined
    task automatic t_unmapped();
        logic [7:0] s;
        rd_reg(4'hc, s);
        chk8("unmapped", 8'h00, s);
        // The last order was a pipelined start on channel six; start reads back as zero.
        rd_reg(hfa_pkg::REG_CTRL, s);
        chk8("ctrl", {1'b0, hfa_pkg::OPT_PIPE, 1'b1, 3'h6, 1'b0}, s);
    endtask : t_unmapped
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_first();
        t_read_mode();
        t_write_read();
        t_pipelined();
        t_unmapped();
        conclude();
    end
    // Thirteen conversions need a few thousand cycles; this bound is far above.
    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        conclude();
    end
endmodule : hfa_host_bench
